// [rtl/maif_regs.vh]
// Constants for the motion axis interrupt factor block
// Assumes inclusion by plain Verilog-2005 design files
`ifndef MAIF_REGS_VH
`define MAIF_REGS_VH

`define MAIF_NUM_GROUPS 17
`define MAIF_NUM_AXES 16
`define MAIF_SYS_GROUP 5'h10
`define MAIF_FACTOR_BITS 16
`define MAIF_GRP_W 5
`define MAIF_FAC_W 4
`define MAIF_TOTAL 272
`define MAIF_AXIS_USED_MASK 16'h7fff

// Axis factor bit positions
`define MAIF_SERVO_ALARM 0
`define MAIF_POS_LIMIT 1
`define MAIF_NEG_LIMIT 2
`define MAIF_HOME_SWITCH 3
`define MAIF_INDEX_PULSE 4
`define MAIF_IN_POSITION 5
`define MAIF_SERVO_WARNING 6
`define MAIF_ZERO_SPEED 7
`define MAIF_COMMAND_STOP 8
`define MAIF_MAX_VELOCITY 9
`define MAIF_ACCELERATING 10
`define MAIF_DECELERATING 11
`define MAIF_NORMAL_STOP 12
`define MAIF_ABNORMAL_STOP 13
`define MAIF_TORQUE_LIMIT 14
`define MAIF_RESERVED_BIT 15

`define MAIF_RESET_ENABLES 16'h0000
`define MAIF_RESET_STATE 16'h0000
`define MAIF_GLOBAL_OFF 1'b0
`define MAIF_SYS_USED_MASK 16'hffff
`define MAIF_ONEHOT_BASE 16'h0001
`define MAIF_WORD_ZERO 16'h0000
`define MAIF_BIT_OFF 1'b0

`endif

// [rtl/maif_group.v]
// One factor group: enables, sticky signaled state, gated request
// Assumes select and strobes are synchronous one-cycle pulses
`timescale 1ns/10ps
`include "maif_regs.vh"

module maif_group #(
	parameter [15:0] USED_MASK = 16'hffff
) (
	input wire clk,
	input wire rst,
	input wire [15:0] cond,
	input wire sel,
	input wire [3:0] fac,
	input wire en_wr,
	input wire en_val,
	input wire clr,
	input wire force_set,
	output reg [15:0] en_r,
	output reg [15:0] state_r,
	output wire req
);

	reg [15:0] en_nxt;
	reg [15:0] state_nxt;
	wire [15:0] onehot;

	assign onehot = `MAIF_ONEHOT_BASE << fac;

	always @* begin
		en_nxt = en_r;
		if (sel && en_wr) begin
			if (en_val)
				en_nxt = en_r | onehot;
			else
				en_nxt = en_r & ~onehot;
		end
		state_nxt = state_r;
		if (sel && clr)
			state_nxt = state_r & ~onehot;
		// [R7] sticky, set beats clear
		state_nxt = state_nxt | cond;
		// [R13] software force
		if (sel && force_set)
			state_nxt = state_nxt | onehot;
		state_nxt = state_nxt & USED_MASK;
		en_nxt = en_nxt & USED_MASK;
	end

	always @(posedge clk) begin
		if (rst) begin
			en_r <= `MAIF_RESET_ENABLES;
			state_r <= `MAIF_RESET_STATE;
		end else begin
			en_r <= en_nxt;
			state_r <= state_nxt;
		end
	end

	// [R2] only enabled factors request
	assign req = |(en_r & state_r);

endmodule // maif_group

// [rtl/maif_top.v]
// Interrupt factor logic for a sixteen-axis motion card
// Assumes host commands arrive as synchronous one-cycle strobes
// Function
// [R1] Global switch off means no interrupt request at all.
// [R2] A factor interrupts only if its own enable is set.
// [R3] Groups 0 to 15 are axes, group 16 is system factors.
// [R4] Axis bits 0-3: alarm, positive limit, negative limit, home.
// [R5] Axis bits 4-7: index pulse, in position, warning, zero speed.
// [R6] Bits 8-14: stop, max velocity, accel, decel, done, abort, torque.
// [R7] Signaled factors stay set until the host clears them.
// [R8] Host clears each serviced factor before waiting again.
// [R9] Host single wait ends on signaled factor or time-out.
// [R10] Host checks state first, suspends only if not signaled.
// [R11] Host multi wait ends on any or all signaled, or time-out.
// [R12] Request is OR of enabled signaled factors, gated globally.
// [R13] Software force sets a factor as if hardware had fired.
`timescale 1ns/10ps
`include "maif_regs.vh"

module maif_top (
	input wire clk,
	input wire rst,
	input wire [15:0] servo_alarm_factor,
	input wire [15:0] positive_limit_factor,
	input wire [15:0] negative_limit_factor,
	input wire [15:0] home_switch_factor,
	input wire [15:0] index_pulse_factor,
	input wire [15:0] in_position_factor,
	input wire [15:0] servo_warning_factor,
	input wire [15:0] zero_speed_factor,
	input wire [15:0] command_stop_factor,
	input wire [15:0] max_velocity_factor,
	input wire [15:0] accelerating_factor,
	input wire [15:0] decelerating_factor,
	input wire [15:0] normal_stop_factor,
	input wire [15:0] abnormal_stop_factor,
	input wire [15:0] torque_limit_factor,
	input wire [15:0] system_factor_cond,
	input wire global_irq_switch_wr,
	input wire global_irq_switch,
	input wire [4:0] cmd_group,
	input wire [3:0] cmd_factor,
	input wire factor_enable_write,
	input wire factor_enable_val,
	input wire factor_clear,
	input wire factor_force,
	input wire [4:0] rd_group,
	input wire [3:0] rd_factor,
	output reg global_irq_en_r,
	output reg rd_enable_r,
	output reg rd_signaled_r,
	output reg [15:0] rd_group_state_r,
	output wire irq_req
);

	////////////////////////////////////////////////////////////////
	// Helpers

	// Group select decode, shared by commands and readback
	function grp_hit;
		input [4:0] g;
		input [31:0] idx;
		begin
			grp_hit = ({27'h0, g} == idx);
		end
	endfunction

	// Factor bit pick, shared by enable and state readback
	function fac_pick;
		input [15:0] word;
		input [3:0] fac;
		begin
			fac_pick = word[fac];
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Axis condition assembly

	wire [15:0] axis_cond [0:15];
	wire [15:0] grp_en [0:16];
	wire [15:0] grp_state [0:16];
	wire [16:0] grp_req;

	genvar a;
	generate
		for (a = 0; a < `MAIF_NUM_AXES; a = a + 1) begin : g_axis
			wire [15:0] c;
			// [R4] low nibble layout
			assign c[`MAIF_SERVO_ALARM] = servo_alarm_factor[a];
			assign c[`MAIF_POS_LIMIT] = positive_limit_factor[a];
			assign c[`MAIF_NEG_LIMIT] = negative_limit_factor[a];
			assign c[`MAIF_HOME_SWITCH] = home_switch_factor[a];
			// [R5] upper low byte
			assign c[`MAIF_INDEX_PULSE] = index_pulse_factor[a];
			assign c[`MAIF_IN_POSITION] = in_position_factor[a];
			assign c[`MAIF_SERVO_WARNING] = servo_warning_factor[a];
			assign c[`MAIF_ZERO_SPEED] = zero_speed_factor[a];
			// [R6] high byte, bit 15 reserved
			assign c[`MAIF_COMMAND_STOP] = command_stop_factor[a];
			assign c[`MAIF_MAX_VELOCITY] = max_velocity_factor[a];
			assign c[`MAIF_ACCELERATING] = accelerating_factor[a];
			assign c[`MAIF_DECELERATING] = decelerating_factor[a];
			assign c[`MAIF_NORMAL_STOP] = normal_stop_factor[a];
			assign c[`MAIF_ABNORMAL_STOP] = abnormal_stop_factor[a];
			assign c[`MAIF_TORQUE_LIMIT] = torque_limit_factor[a];
			assign c[`MAIF_RESERVED_BIT] = `MAIF_BIT_OFF;
			assign axis_cond[a] = c;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Command target decode

	// Group above 16 matches no slot, so its commands are dropped
	wire [16:0] grp_sel;

	genvar s;
	generate
		for (s = 0; s < `MAIF_NUM_GROUPS; s = s + 1) begin : g_sel
			assign grp_sel[s] = grp_hit(cmd_group, s);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Factor groups

	genvar g;
	generate
		// [R3] groups 0-15 axes, 16 system
		for (g = 0; g < `MAIF_NUM_GROUPS; g = g + 1) begin : g_grp
			wire sel;
			wire [15:0] cond;
			assign sel = grp_sel[g];
			if (g < `MAIF_NUM_AXES) begin : g_ax
				assign cond = axis_cond[g];
			end else begin : g_sys
				assign cond = system_factor_cond;
			end
			// System group keeps all sixteen bits usable
			maif_group #(
				.USED_MASK((g < `MAIF_NUM_AXES) ?
					`MAIF_AXIS_USED_MASK : `MAIF_SYS_USED_MASK)
			) u_grp (
				.clk(clk),
				.rst(rst),
				.cond(cond),
				.sel(sel),
				.fac(cmd_factor),
				.en_wr(factor_enable_write),
				.en_val(factor_enable_val),
				.clr(factor_clear),
				.force_set(factor_force),
				.en_r(grp_en[g]),
				.state_r(grp_state[g]),
				.req(grp_req[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Global switch and request

	reg global_irq_en_nxt;
	wire any_req;

	// Switch holds between writes; a write lands on the next edge
	always @* begin
		global_irq_en_nxt = global_irq_en_r;
		if (global_irq_switch_wr)
			global_irq_en_nxt = global_irq_switch;
	end

	always @(posedge clk) begin
		if (rst)
			global_irq_en_r <= `MAIF_GLOBAL_OFF;
		else
			global_irq_en_r <= global_irq_en_nxt;
	end

	////////////////////////////////////////////////////////////////
	// Request

	// [R12] OR of enabled signaled factors
	assign any_req = |grp_req;

	// Level request: stays up until every live factor is cleared
	// [R1] global gate
	assign irq_req = global_irq_en_r & any_req;

	////////////////////////////////////////////////////////////////
	// Readback; out-of-range group reads as zero

	reg [15:0] rd_en_w;
	reg [15:0] rd_st_w;
	reg rd_enable_nxt;
	reg rd_signaled_nxt;
	reg [15:0] rd_group_state_nxt;
	integer i;

	always @* begin
		rd_en_w = `MAIF_WORD_ZERO;
		rd_st_w = `MAIF_WORD_ZERO;
		for (i = 0; i < `MAIF_NUM_GROUPS; i = i + 1) begin
			if (grp_hit(rd_group, i)) begin
				rd_en_w = grp_en[i];
				rd_st_w = grp_state[i];
			end
		end
	end

	// Reserved axis bit reads zero, since the group masks it
	always @* begin
		rd_enable_nxt = fac_pick(rd_en_w, rd_factor);
		rd_signaled_nxt = fac_pick(rd_st_w, rd_factor);
		rd_group_state_nxt = rd_st_w;
	end

	// Registered readback costs one cycle but keeps data glitch-free
	always @(posedge clk) begin
		if (rst) begin
			rd_enable_r <= `MAIF_BIT_OFF;
			rd_signaled_r <= `MAIF_BIT_OFF;
			rd_group_state_r <= `MAIF_RESET_STATE;
		end else begin
			rd_enable_r <= rd_enable_nxt;
			rd_signaled_r <= rd_signaled_nxt;
			rd_group_state_r <= rd_group_state_nxt;
		end
	end

endmodule // maif_top

// [verification/maif_properties.sv]
// Checker for the factor block, on top ports only
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module maif_properties (
	input wire clk,
	input wire rst,
	input wire global_irq_en_r,
	input wire irq_req,
	input wire rd_enable_r,
	input wire rd_signaled_r,
	input wire [15:0] rd_group_state_r,
	input wire [4:0] rd_group,
	input wire [3:0] rd_factor,
	input wire [4:0] cmd_group,
	input wire [3:0] cmd_factor,
	input wire factor_force,
	input wire factor_clear
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire hit = rd_group == cmd_group && rd_factor == cmd_factor &&
	cmd_factor != 4'hf && cmd_group <= 5'h10;
gate_off_a: assert property (!global_irq_en_r |-> !irq_req)
	else $error("request while globally off");
src_req_a: assert property (rd_enable_r && rd_signaled_r &&
	$past(global_irq_en_r) |-> $past(irq_req)) else $error("request missing");
factor_sticky_a: assert property (rd_signaled_r && $stable(rd_group) &&
	$stable(rd_factor) && !$past(factor_clear) |=> rd_signaled_r)
	else $error("factor dropped");
force_set_a: assert property (factor_force && hit ##1
	$stable(rd_group) && $stable(rd_factor) |=> rd_signaled_r)
	else $error("force ignored");
resv_word_a: assert property ($past(rd_group) < 5'h10 |->
	!rd_group_state_r[15]) else $error("reserved bit set");
resv_fac_a: assert property ($past(rd_group) < 5'h10 &&
	$past(rd_factor) == 4'hf |-> !rd_enable_r && !rd_signaled_r)
	else $error("reserved factor live");
bad_group_a: assert property ($past(rd_group) > 5'h10 |->
	rd_group_state_r == 16'h0000) else $error("bad group reads");
bit_agree_a: assert property (
	rd_signaled_r == rd_group_state_r[$past(rd_factor)])
	else $error("bit and word disagree");
cover property (irq_req);
cover property (factor_force && hit);
cover property (rd_enable_r && rd_signaled_r);
endmodule // maif_properties
bind maif_top maif_properties i_chk (.*);

// [verification/maif_host.sv]
// Host software model: factor commands and bounded waits
// Assumes the bench calls its tasks; strobes last one cycle
`timescale 1ns/10ps
module maif_host (
	input wire clk,
	input wire rd_signaled_r,
	input wire [15:0] rd_group_state_r,
	output logic global_irq_switch_wr,
	output logic global_irq_switch,
	output logic [4:0] cmd_group,
	output logic [3:0] cmd_factor,
	output logic factor_enable_write,
	output logic factor_enable_val,
	output logic factor_clear,
	output logic factor_force,
	output logic [4:0] rd_group,
	output logic [3:0] rd_factor
);
initial {global_irq_switch_wr, global_irq_switch, cmd_group, cmd_factor,
	factor_enable_write, factor_enable_val, factor_clear, factor_force,
	rd_group, rd_factor} = '0;
// Kind 0 enable, 1 clear, 2 force, 3 global switch
task cmd(input int k, input [4:0] g, input [3:0] f, input v);
	@(negedge clk);
	{cmd_group, cmd_factor, rd_group, rd_factor} = {g, f, g, f};
	{factor_enable_val, global_irq_switch} = {v, v};
	{factor_enable_write, factor_clear} = {k == 0, k == 1};
	{factor_force, global_irq_switch_wr} = {k == 2, k == 3};
	@(negedge clk);
	{factor_enable_write, factor_clear, factor_force} = '0;
	global_irq_switch_wr = 0;
endtask
task sel(input [4:0] g, input [3:0] f);
	@(negedge clk);
	{rd_group, rd_factor} = {g, f};
	@(negedge clk);
endtask
task wait_one(input [4:0] g, input [3:0] f, input int lim, output bit ok);
	sel(g, f);
	ok = rd_signaled_r;
	repeat (lim) if (!ok) begin
		@(negedge clk);
		ok = rd_signaled_r;
	end
endtask
task service(input [4:0] g, input [3:0] f, input int lim, output bit ok);
	wait_one(g, f, lim, ok);
	if (ok) cmd(1, g, f, 0);
endtask
task wait_multi(input [4:0] g, input [15:0] m, input bit want_all,
	input int lim, output bit ok);
	sel(g, 4'h0);
	ok = want_all ? (rd_group_state_r & m) == m : |(rd_group_state_r & m);
	repeat (lim) if (!ok) begin
		@(negedge clk);
		ok = want_all ? (rd_group_state_r & m) == m :
			|(rd_group_state_r & m);
	end
endtask
endmodule // maif_host

// [verification/maif_top_bench.sv]
// Self-checking bench for the interrupt factor block
// Assumes the host model drives every command input
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
	error_cnt++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module maif_top_bench;
logic clk = 0, rst = 1, irq_req, global_irq_en_r, rd_enable_r;
logic rd_signaled_r, global_irq_switch_wr, global_irq_switch;
logic factor_enable_write, factor_enable_val, factor_clear, factor_force;
logic [15:0] cv [15];
logic [15:0] system_factor_cond = '0, rd_group_state_r;
logic [4:0] cmd_group, rd_group;
logic [3:0] cmd_factor, rd_factor;
int error_cnt = 0, checks_done = 0;
bit ok;
wire [15:0] servo_alarm_factor = cv[0], positive_limit_factor = cv[1],
	negative_limit_factor = cv[2], home_switch_factor = cv[3],
	index_pulse_factor = cv[4], in_position_factor = cv[5],
	servo_warning_factor = cv[6], zero_speed_factor = cv[7],
	command_stop_factor = cv[8], max_velocity_factor = cv[9],
	accelerating_factor = cv[10], decelerating_factor = cv[11],
	normal_stop_factor = cv[12], abnormal_stop_factor = cv[13],
	torque_limit_factor = cv[14];
maif_top i_dut (.*);
maif_host i_host (.*);
always #5 clk = ~clk;
initial foreach (cv[i]) cv[i] = '0;
task end_of_test;
	if (error_cnt == 0 && checks_done > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////
// One-cycle pulses: state must persist after conditions drop
// Axis g holds factor g, axis 15 nothing, group 16 its own word
function automatic logic [15:0] map_exp(input int g);
	return g < 15 ? 16'h0001 << g : g == 16 ? 16'hc35a : 16'h0000;
endfunction
task t_map;
	@(negedge clk);
	foreach (cv[i]) cv[i] = 16'h0001 << i;
	system_factor_cond = 16'hc35a;
	@(negedge clk);
	foreach (cv[i]) cv[i] = '0;
	system_factor_cond = '0;
	for (int g = 0; g < 18; g++) begin
		i_host.sel(g[4:0], 4'h0);
		`CHK(rd_group_state_r, map_exp(g))
	end
endtask
task t_irq;
	i_host.cmd(3, 0, 0, 1);
	`CHK(global_irq_en_r, 1'b1)
	`CHK(irq_req, 1'b0)
	i_host.cmd(0, 5'h03, 4'h3, 1);
	`CHK(irq_req, 1'b1)
	i_host.sel(5'h03, 4'h3);
	`CHK(rd_enable_r, 1'b1)
	i_host.cmd(3, 0, 0, 0);
	`CHK(global_irq_en_r, 1'b0)
	`CHK(irq_req, 1'b0)
	i_host.cmd(3, 0, 0, 1);
	i_host.cmd(1, 5'h03, 4'h3, 0);
	`CHK(irq_req, 1'b0)
	i_host.cmd(2, 5'h03, 4'h3, 0);
	`CHK(irq_req, 1'b1)
	i_host.cmd(0, 5'h03, 4'h3, 0);
	`CHK(irq_req, 1'b0)
	i_host.cmd(0, 5'h03, 4'h3, 1);
	`CHK(irq_req, 1'b1)
endtask
task t_wait;
	i_host.service(5'h03, 4'h3, 4, ok);
	`CHK(ok, 1'b1)
	`CHK(irq_req, 1'b0)
	i_host.wait_one(5'h03, 4'h3, 4, ok);
	`CHK(ok, 1'b0)
endtask
// Axis bit 15 stays dead; system bit 15 is live
task t_resv;
	i_host.cmd(0, 5'h02, 4'hf, 1);
	i_host.cmd(2, 5'h02, 4'hf, 0);
	i_host.sel(5'h02, 4'hf);
	`CHK(rd_enable_r, 1'b0)
	`CHK(rd_signaled_r, 1'b0)
	`CHK(irq_req, 1'b0)
	`CHK(rd_group_state_r[15], 1'b0)
	i_host.cmd(0, 5'h10, 4'hf, 1);
	`CHK(irq_req, 1'b1)
	i_host.cmd(1, 5'h10, 4'hf, 0);
	`CHK(irq_req, 1'b0)
endtask
// Multi waits on group 16, then clear against a live condition
task t_multi;
	i_host.wait_multi(5'h10, 16'h0006, 1'b0, 3, ok);
	`CHK(ok, 1'b1)
	i_host.wait_multi(5'h10, 16'h0006, 1'b1, 3, ok);
	`CHK(ok, 1'b0)
	i_host.cmd(2, 5'h10, 4'h2, 0);
	i_host.wait_multi(5'h10, 16'h0006, 1'b1, 3, ok);
	`CHK(ok, 1'b1)
	cv[7] = 16'h0020;
	i_host.cmd(1, 5'h05, 4'h7, 0);
	cv[7] = '0;
	i_host.sel(5'h05, 4'h7);
	`CHK(rd_signaled_r, 1'b1)
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	repeat (16) @(negedge clk);
	rst = 0;
	`CHK(irq_req, 1'b0)
	t_map;
	t_irq;
	t_wait;
	t_resv;
	t_multi;
	end_of_test;
end
// Run needs about 110 cycles
initial begin
	#20000;
	error_cnt++;
	end_of_test;
end
endmodule // maif_top_bench
